/* hw/iex_core.sv */
// Executor for immediate, internal register and software trap instructions
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module iex_core #(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic MEM_REQ_OUT,
  output logic MEM_WE_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [15:0] MEM_WDATA_OUT,
  input wire logic [15:0] MEM_RDATA_IN,
  input wire logic MEM_ACK_IN,
  input wire logic INTERRUPT_REQUEST_IN,
  output logic IRQ_ACCEPT_OUT
);
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_DECODE, S_IMM, S_REG_RD, S_EXEC, S_REG_WR, S_SRC_RD,
    S_SRC_INC, S_SRC_SYM, S_SRC_IDX, S_VEC_WS, S_VEC_PC, S_SAVE, S_RET, S_DONE
  } iex_state_t;

  iex_state_t state_ff;
  logic [15:0] program_counter_ff, ws_base_ff, status_word_ff;
  logic [15:0] instr_ff, immediate_word_ff, opnd_ff, ea_ff, wr_data_ff;
  logic [15:0] old_ws_ff, old_pc_ff, old_sw_ff;
  logic [1:0] cnt_ff;
  logic run_ff, illegal_ff, trap_done_ff;
  logic pready_ff, pslverr_ff, irq_accept_ff;
  logic [31:0] prdata_ff;
  logic irq_meta_ff, irq_sync_ff;
  logic mem_req_ff, mem_we_ff;
  logic [15:0] mem_addr_ff, mem_wdata_ff;
  logic nxt_req, nxt_we;
  logic [15:0] nxt_addr, nxt_wdata;
  logic [10:0] opc;
  logic [3:0] reg_field, trap_num, source_register_field, save_reg;
  logic [1:0] source_mode_field;
  logic mem_done, apb_fire, apb_wr, reg_hit;
  logic [7:0] apb_ofs;
  iex_pkg::iex_alu_op_t alu_op;
  logic [15:0] alu_res;
  logic f_lgt, f_agt, f_eq, f_c, f_ov;

  // Instruction fields; documented bit 0 is the msb
  assign opc = instr_ff[15:5];
  assign reg_field = instr_ff[3:0];
  assign trap_num = instr_ff[9:6];
  assign source_mode_field = instr_ff[5:4];
  assign source_register_field = instr_ff[3:0];
  assign mem_done = mem_req_ff && MEM_ACK_IN;
  assign apb_fire = PSEL_IN && PENABLE_IN && pready_ff;
  assign apb_wr = apb_fire && PWRITE_IN;
  assign apb_ofs = 8'(PADDR_IN);
  assign reg_hit = (apb_ofs == iex_pkg::REG_CTRL_OFS) || (apb_ofs == iex_pkg::REG_STATE_OFS) ||
                   (apb_ofs == iex_pkg::REG_PC_OFS) || (apb_ofs == iex_pkg::REG_WS_OFS) ||
                   (apb_ofs == iex_pkg::REG_STW_OFS);

  // Operation select from the opcode
  always_comb begin
    unique case (opc)
      iex_pkg::OPC_ADI: alu_op = iex_pkg::ALU_ADD;
      iex_pkg::OPC_ANDV: alu_op = iex_pkg::ALU_AND;
      iex_pkg::OPC_ORV: alu_op = iex_pkg::ALU_OR;
      iex_pkg::OPC_CPI: alu_op = iex_pkg::ALU_CMP;
      default: alu_op = iex_pkg::ALU_LOAD;
    endcase
  end

  iex_imm_alu u_alu (
    .op_in(alu_op),
    .reg_in(opnd_ff),
    .imm_in(immediate_word_ff),
    .result_out(alu_res),
    .lgt_out(f_lgt),
    .agt_out(f_agt),
    .eq_out(f_eq),
    .carry_out(f_c),
    .ovf_out(f_ov)
  );

  // Register number written during the trap save sequence
  always_comb begin
    unique case (cnt_ff)
      2'd0: save_reg = iex_pkg::R_EA;
      2'd1: save_reg = iex_pkg::R_OLD_WS;
      2'd2: save_reg = iex_pkg::R_OLD_PC;
      default: save_reg = iex_pkg::R_OLD_SW;
    endcase
  end

  // Memory request built from the current state
  always_comb begin
    nxt_req = 1'b1;
    nxt_we = 1'b0;
    nxt_wdata = wr_data_ff;
    nxt_addr = program_counter_ff;
    unique case (state_ff)
      S_FETCH, S_IMM, S_SRC_SYM: nxt_addr = program_counter_ff;
      S_REG_RD: nxt_addr = ws_base_ff + {11'h000, reg_field, 1'b0};
      S_REG_WR: begin
        nxt_we = 1'b1;
        nxt_addr = ws_base_ff + {11'h000, reg_field, 1'b0};
      end
      S_SRC_RD, S_SRC_IDX: nxt_addr = ws_base_ff + {11'h000, source_register_field, 1'b0};
      S_SRC_INC: begin
        nxt_we = 1'b1;
        nxt_addr = ws_base_ff + {11'h000, source_register_field, 1'b0};
      end
      S_VEC_WS: nxt_addr = iex_pkg::TRAP_VEC_BASE + {10'h000, trap_num, 2'b00};
      S_VEC_PC: nxt_addr = iex_pkg::TRAP_VEC_BASE + iex_pkg::TRAP_VEC_PC_OFS + {10'h000, trap_num, 2'b00};
      S_SAVE: begin
        nxt_we = 1'b1;
        nxt_addr = ws_base_ff + {11'h000, save_reg, 1'b0};
        unique case (cnt_ff)
          2'd0: nxt_wdata = ea_ff;
          2'd1: nxt_wdata = old_ws_ff;
          2'd2: nxt_wdata = old_pc_ff;
          default: nxt_wdata = old_sw_ff;
        endcase
      end
      S_RET: nxt_addr = ws_base_ff + {11'h000, iex_pkg::R_OLD_SW - {2'b00, cnt_ff}, 1'b0};
      default: nxt_req = 1'b0;
    endcase
  end

  // Memory port: request held until acknowledged, then dropped one cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 16'h0000;
    end else if (!mem_req_ff) begin
      mem_req_ff <= nxt_req;
      mem_we_ff <= nxt_we;
      mem_addr_ff <= nxt_addr;
      mem_wdata_ff <= nxt_wdata;
    end else if (MEM_ACK_IN) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
    end
  end

  // Instruction sequencer and processor registers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_ff <= S_IDLE;
      program_counter_ff <= iex_pkg::PC_RST;
      ws_base_ff <= iex_pkg::WS_RST;
      status_word_ff <= iex_pkg::STW_RST;
      instr_ff <= 16'h0000;
      immediate_word_ff <= 16'h0000;
      opnd_ff <= 16'h0000;
      ea_ff <= 16'h0000;
      wr_data_ff <= 16'h0000;
      old_ws_ff <= 16'h0000;
      old_pc_ff <= 16'h0000;
      old_sw_ff <= 16'h0000;
      cnt_ff <= 2'd0;
      run_ff <= 1'b0;
      illegal_ff <= 1'b0;
      trap_done_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (apb_wr && apb_ofs == iex_pkg::REG_PC_OFS) program_counter_ff <= PWDATA_IN[15:0];
          if (apb_wr && apb_ofs == iex_pkg::REG_WS_OFS) ws_base_ff <= PWDATA_IN[15:0];
          if (apb_wr && apb_ofs == iex_pkg::REG_STW_OFS) status_word_ff <= PWDATA_IN[15:0];
          if (apb_wr && apb_ofs == iex_pkg::REG_CTRL_OFS && PWDATA_IN[iex_pkg::CTRL_RUN_BIT]) begin
            run_ff <= 1'b1;
            illegal_ff <= 1'b0;
            state_ff <= S_FETCH;
          end
        end
        S_FETCH: if (mem_done) begin
          instr_ff <= MEM_RDATA_IN;
          program_counter_ff <= program_counter_ff + 16'h0002;
          state_ff <= S_DECODE;
        end
        S_DECODE: begin
          trap_done_ff <= 1'b0;
          cnt_ff <= 2'd0;
          if (instr_ff[15:10] == iex_pkg::OPC_TRAP) begin
            unique case (source_mode_field)
              iex_pkg::MODE_REG: begin
                ea_ff <= ws_base_ff + {11'h000, source_register_field, 1'b0};
                state_ff <= S_VEC_WS;
              end
              iex_pkg::MODE_SYM: state_ff <= S_SRC_SYM;
              default: state_ff <= S_SRC_RD;
            endcase
          end else begin
            unique case (opc)
              iex_pkg::OPC_LDI, iex_pkg::OPC_ADI, iex_pkg::OPC_ANDV, iex_pkg::OPC_ORV, iex_pkg::OPC_CPI,
              iex_pkg::OPC_LWB, iex_pkg::OPC_LMK: state_ff <= S_IMM;
              iex_pkg::OPC_SSW: begin
                wr_data_ff <= status_word_ff;
                state_ff <= S_REG_WR;
              end
              iex_pkg::OPC_SWB: begin
                wr_data_ff <= ws_base_ff;
                state_ff <= S_REG_WR;
              end
              iex_pkg::OPC_RET: state_ff <= S_RET;
              default: begin
                illegal_ff <= 1'b1;
                run_ff <= 1'b0;
                state_ff <= S_IDLE;
              end
            endcase
          end
        end
        S_IMM: if (mem_done) begin
          immediate_word_ff <= MEM_RDATA_IN;
          program_counter_ff <= program_counter_ff + 16'h0002;
          if (opc == iex_pkg::OPC_LWB) begin
            ws_base_ff <= MEM_RDATA_IN;
            state_ff <= S_DONE;
          end else if (opc == iex_pkg::OPC_LMK) begin
            status_word_ff[iex_pkg::SW_MASK_HI:iex_pkg::SW_MASK_LO] <= MEM_RDATA_IN[3:0];
            state_ff <= S_DONE;
          end else if (opc == iex_pkg::OPC_LDI) begin
            state_ff <= S_EXEC;
          end else begin
            state_ff <= S_REG_RD;
          end
        end
        S_REG_RD: if (mem_done) begin
          opnd_ff <= MEM_RDATA_IN;
          state_ff <= S_EXEC;
        end
        S_EXEC: begin
          status_word_ff[iex_pkg::SW_LGT_BIT] <= f_lgt;
          status_word_ff[iex_pkg::SW_AGT_BIT] <= f_agt;
          status_word_ff[iex_pkg::SW_EQ_BIT] <= f_eq;
          if (opc == iex_pkg::OPC_ADI) begin
            status_word_ff[iex_pkg::SW_CARRY_BIT] <= f_c;
            status_word_ff[iex_pkg::SW_OVF_BIT] <= f_ov;
          end
          wr_data_ff <= alu_res;
          state_ff <= (opc == iex_pkg::OPC_CPI) ? S_DONE : S_REG_WR;
        end
        S_REG_WR: if (mem_done) state_ff <= S_DONE;
        S_SRC_RD: if (mem_done) begin
          ea_ff <= MEM_RDATA_IN;
          wr_data_ff <= MEM_RDATA_IN + 16'h0002;
          state_ff <= (source_mode_field == iex_pkg::MODE_INC) ? S_SRC_INC : S_VEC_WS;
        end
        S_SRC_INC: if (mem_done) state_ff <= S_VEC_WS;
        S_SRC_SYM: if (mem_done) begin
          ea_ff <= MEM_RDATA_IN;
          program_counter_ff <= program_counter_ff + 16'h0002;
          state_ff <= (source_register_field == 4'h0) ? S_VEC_WS : S_SRC_IDX;
        end
        S_SRC_IDX: if (mem_done) begin
          ea_ff <= ea_ff + MEM_RDATA_IN;
          state_ff <= S_VEC_WS;
        end
        S_VEC_WS: if (mem_done) begin
          old_ws_ff <= ws_base_ff;
          old_sw_ff <= status_word_ff;
          ws_base_ff <= MEM_RDATA_IN;
          state_ff <= S_VEC_PC;
        end
        S_VEC_PC: if (mem_done) begin
          old_pc_ff <= program_counter_ff;
          program_counter_ff <= MEM_RDATA_IN;
          status_word_ff[iex_pkg::SW_TRAP_BIT] <= 1'b1;
          state_ff <= S_SAVE;
        end
        S_SAVE: if (mem_done) begin
          cnt_ff <= cnt_ff + 2'd1;
          if (cnt_ff == 2'd3) begin
            trap_done_ff <= 1'b1;
            state_ff <= S_DONE;
          end
        end
        S_RET: if (mem_done) begin
          cnt_ff <= cnt_ff + 2'd1;
          unique case (cnt_ff)
            2'd0: status_word_ff <= MEM_RDATA_IN;
            2'd1: program_counter_ff <= MEM_RDATA_IN;
            default: begin
              ws_base_ff <= MEM_RDATA_IN;
              state_ff <= S_DONE;
            end
          endcase
        end
        S_DONE: begin
          if (apb_wr && apb_ofs == iex_pkg::REG_CTRL_OFS) run_ff <= PWDATA_IN[iex_pkg::CTRL_RUN_BIT];
          state_ff <= (run_ff && !(apb_wr && apb_ofs == iex_pkg::REG_CTRL_OFS &&
                      !PWDATA_IN[iex_pkg::CTRL_RUN_BIT])) ? S_FETCH : S_IDLE;
        end
      endcase
      if (state_ff != S_IDLE && state_ff != S_DONE && apb_wr && apb_ofs == iex_pkg::REG_CTRL_OFS)
        run_ff <= PWDATA_IN[iex_pkg::CTRL_RUN_BIT];
    end
  end

  // Interrupt request pin synchroniser
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      irq_meta_ff <= 1'b0;
      irq_sync_ff <= 1'b0;
    end else begin
      irq_meta_ff <= INTERRUPT_REQUEST_IN;
      irq_sync_ff <= irq_meta_ff;
    end
  end

  // Request sampled at instruction end, never right after a trap
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) irq_accept_ff <= 1'b0;
    else irq_accept_ff <= (state_ff == S_DONE) && irq_sync_ff && !trap_done_ff;
  end

  // APB slave: one wait cycle, error on unmapped offsets
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= PSEL_IN && PENABLE_IN && !pready_ff;
      pslverr_ff <= PSEL_IN && PENABLE_IN && !pready_ff && !reg_hit;
      prdata_ff <= 32'h00000000;
      if (PSEL_IN && PENABLE_IN && !pready_ff && !PWRITE_IN) begin
        unique case (apb_ofs)
          iex_pkg::REG_CTRL_OFS: prdata_ff <= {31'h00000000, run_ff};
          iex_pkg::REG_STATE_OFS: prdata_ff <= {30'h00000000, illegal_ff, state_ff != S_IDLE};
          iex_pkg::REG_PC_OFS: prdata_ff <= {16'h0000, program_counter_ff};
          iex_pkg::REG_WS_OFS: prdata_ff <= {16'h0000, ws_base_ff};
          iex_pkg::REG_STW_OFS: prdata_ff <= {16'h0000, status_word_ff};
          default: prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA_OUT = prdata_ff;
  assign PREADY_OUT = pready_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign MEM_REQ_OUT = mem_req_ff;
  assign MEM_WE_OUT = mem_we_ff;
  assign MEM_ADDR_OUT = mem_addr_ff;
  assign MEM_WDATA_OUT = mem_wdata_ff;
  assign IRQ_ACCEPT_OUT = irq_accept_ff;
endmodule : iex_core

/* hw/iex_imm_alu.sv */
// Immediate operation arithmetic and condition flag generation
`timescale 1ns/100ps
module iex_imm_alu (
  input wire iex_pkg::iex_alu_op_t op_in,
  input wire logic [15:0] reg_in,
  input wire logic [15:0] imm_in,
  output logic [15:0] result_out,
  output logic lgt_out,
  output logic agt_out,
  output logic eq_out,
  output logic carry_out,
  output logic ovf_out
);
  logic [16:0] sum;

  // Add with carry out
  assign sum = {1'b0, reg_in} + {1'b0, imm_in};

  // Result selection per operation
  always_comb begin
    result_out = imm_in;
    unique case (op_in)
      iex_pkg::ALU_LOAD: result_out = imm_in;
      iex_pkg::ALU_ADD: result_out = sum[15:0];
      iex_pkg::ALU_AND: result_out = reg_in & imm_in;
      iex_pkg::ALU_OR: result_out = reg_in | imm_in;
      iex_pkg::ALU_CMP: result_out = reg_in;
    endcase
  end

  // Compare flags: register against immediate, or result against zero
  always_comb begin
    if (op_in == iex_pkg::ALU_CMP) begin
      lgt_out = reg_in > imm_in;
      agt_out = $signed(reg_in) > $signed(imm_in);
      eq_out = reg_in == imm_in;
    end else begin
      lgt_out = result_out != 16'h0000;
      agt_out = !result_out[15] && (result_out != 16'h0000);
      eq_out = result_out == 16'h0000;
    end
    carry_out = sum[16];
    ovf_out = (reg_in[15] == imm_in[15]) && (sum[15] != reg_in[15]);
  end
endmodule : iex_imm_alu

/* hw/iex_pkg.sv */
// Shared constants and types for the immediate and trap instruction executor
package iex_pkg;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATE_OFS = 8'h04;
  localparam logic [7:0] REG_PC_OFS = 8'h08;
  localparam logic [7:0] REG_WS_OFS = 8'h0C;
  localparam logic [7:0] REG_STW_OFS = 8'h10;
  // Control and state field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_ILLEGAL_BIT = 1;
  // Reset values of the processor registers
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] WS_RST = 16'h0000;
  localparam logic [15:0] STW_RST = 16'h0000;
  // Status word bit positions; documented bit n sits at index 15-n
  localparam int SW_LGT_BIT = 15;
  localparam int SW_AGT_BIT = 14;
  localparam int SW_EQ_BIT = 13;
  localparam int SW_CARRY_BIT = 12;
  localparam int SW_OVF_BIT = 11;
  localparam int SW_TRAP_BIT = 9;
  localparam int SW_MASK_LO = 0;
  localparam int SW_MASK_HI = 3;
  // Top eleven opcode bits of the immediate, internal register and return group; top six bits for the trap
  localparam logic [10:0] OPC_LDI = 11'h010;
  localparam logic [10:0] OPC_ADI = 11'h011;
  localparam logic [10:0] OPC_ANDV = 11'h012;
  localparam logic [10:0] OPC_ORV = 11'h013;
  localparam logic [10:0] OPC_CPI = 11'h014;
  localparam logic [10:0] OPC_SWB = 11'h015;
  localparam logic [10:0] OPC_SSW = 11'h016;
  localparam logic [10:0] OPC_LWB = 11'h017;
  localparam logic [10:0] OPC_LMK = 11'h018;
  localparam logic [10:0] OPC_RET = 11'h01C;
  localparam logic [5:0] OPC_TRAP = 6'h0B;
  // Trap vector table base and workspace register numbers used
  localparam logic [15:0] TRAP_VEC_BASE = 16'h0040;
  localparam logic [15:0] TRAP_VEC_PC_OFS = 16'h0002;
  localparam logic [3:0] R_EA = 4'hB;
  localparam logic [3:0] R_OLD_WS = 4'hD;
  localparam logic [3:0] R_OLD_PC = 4'hE;
  localparam logic [3:0] R_OLD_SW = 4'hF;
  // Source addressing modes
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_SYM = 2'h2;
  localparam logic [1:0] MODE_INC = 2'h3;
  // Immediate arithmetic operations
  typedef enum logic [2:0] {ALU_LOAD, ALU_ADD, ALU_AND, ALU_OR, ALU_CMP} iex_alu_op_t;
endpackage : iex_pkg

/* test/iex_core_monitor.sv */
// Port-level checker for the instruction executor
`timescale 1ns/100ps
module iex_core_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic MEM_REQ_OUT,
  input wire logic MEM_WE_OUT,
  input wire logic [15:0] MEM_ADDR_OUT,
  input wire logic [15:0] MEM_WDATA_OUT,
  input wire logic [15:0] MEM_RDATA_IN,
  input wire logic MEM_ACK_IN,
  input wire logic INTERRUPT_REQUEST_IN,
  input wire logic IRQ_ACCEPT_OUT
);
  logic rd_ack;
  logic vec1_ff;
  logic trap_win_ff;
  logic [15:0] vec_addr_ff;
  logic [7:0] pa;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // Read completions and the decoded address byte
  assign rd_ack = MEM_REQ_OUT && MEM_ACK_IN && !MEM_WE_OUT;
  assign pa = PADDR_IN[7:0];
  // Remember vector reads; the window after a trap lasts until the next fetch
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      vec1_ff <= 1'b0;
      trap_win_ff <= 1'b0;
      vec_addr_ff <= 16'h0000;
    end else if (rd_ack) begin
      vec1_ff <= MEM_ADDR_OUT >= 16'h0040 && MEM_ADDR_OUT <= 16'h007C && MEM_ADDR_OUT[1:0] == 2'h0;
      trap_win_ff <= vec1_ff;
      vec_addr_ff <= MEM_ADDR_OUT;
    end
  end
  AST_APB_ONE_WAIT: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  AST_RDATA_IDLE: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h00000000)
    else $error("read data not zero outside ready");
  AST_ERR_UNMAPPED: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT && (pa > 8'h10 || pa[1:0] != 2'h0)
    |=> PSLVERR_OUT && PRDATA_OUT == 32'h00000000) else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT && pa <= 8'h10 && pa[1:0] == 2'h0
    |=> !PSLVERR_OUT) else $error("mapped access refused");
  AST_MEM_HOLD: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT)
    && $stable(MEM_WE_OUT) && $stable(MEM_WDATA_OUT)) else $error("memory request changed before answer");
  AST_MEM_GAP: assert property (MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT)
    else $error("memory request too soon after answer");
  AST_MEM_EVEN: assert property (MEM_REQ_OUT |-> !MEM_ADDR_OUT[0])
    else $error("odd memory address");
  AST_VEC_PAIR: assert property ($rose(MEM_REQ_OUT) && vec1_ff |-> !MEM_WE_OUT
    && MEM_ADDR_OUT == vec_addr_ff + 16'h0002) else $error("vector second word not read next");
  AST_NO_IRQ_AFTER_TRAP: assert property (trap_win_ff |-> !IRQ_ACCEPT_OUT)
    else $error("interrupt taken right after trap");
  AST_IRQ_PULSE: assert property (IRQ_ACCEPT_OUT |=> !IRQ_ACCEPT_OUT)
    else $error("interrupt accept held too long");
  COV_TRAP: cover property (trap_win_ff);
  COV_SLVERR: cover property (PSLVERR_OUT);
  COV_IRQ: cover property (IRQ_ACCEPT_OUT);
endmodule : iex_core_monitor

bind iex_core iex_core_monitor #(.ADDR_W(ADDR_W)) iex_core_monitor_inst (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .MEM_REQ_OUT(MEM_REQ_OUT),
  .MEM_WE_OUT(MEM_WE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
  .MEM_RDATA_IN(MEM_RDATA_IN), .MEM_ACK_IN(MEM_ACK_IN), .INTERRUPT_REQUEST_IN(INTERRUPT_REQUEST_IN),
  .IRQ_ACCEPT_OUT(IRQ_ACCEPT_OUT));

/* test/iex_mem_model.sv */
// Word memory holding code, workspaces and vectors, answering fast or slow
`timescale 1ns/100ps
module iex_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic ack_out
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_ff;
  logic [1:0] wait_ff;
  logic [1:0] step_ff;
  // Word shown only with the answer; otherwise the inverse of the last one
  assign rdata_out = ack_out ? mem[addr_in[15:1]] : ~last_ff;
  // Answer after a wait that is zero when fast and varies when slow
  always @(posedge clk_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      wait_ff <= 2'h0;
      step_ff <= 2'h0;
      last_ff <= 16'h0000;
    end else if (req_in && ack_out) begin
      ack_out <= 1'b0;
      step_ff <= step_ff + 2'h1;
      wait_ff <= slow_in ? step_ff : 2'h0;
      if (we_in) mem[addr_in[15:1]] <= wdata_in;
      else last_ff <= mem[addr_in[15:1]];
    end else if (req_in && wait_ff == 2'h0) ack_out <= 1'b1;
    else if (req_in) wait_ff <= wait_ff - 2'h1;
    else ack_out <= 1'b0;
  end
endmodule : iex_mem_model

/* test/tb.sv */
// Self-checking bench for the instruction executor
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, mreq, mwe, mack, irq_acc;
  logic [15:0] maddr, mwdata, mrdata;
  logic irq = 1'b0;
  logic slow = 1'b0;
  logic want = 1'b0;
  logic in_win = 1'b0;
  logic [15:0] seed = 16'h1704;
  logic [32:0] e_rd;
  logic [32:0] rd_q[$];
  logic [31:0] wr_q[$];
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int irq_total = 0;
  int irq_win = 0;
  // Clock at 25 MHz
  always #20 clk = ~clk;
  iex_core #(.ADDR_W(8)) iex_core_inst (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe), .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata),
    .MEM_RDATA_IN(mrdata), .MEM_ACK_IN(mack), .INTERRUPT_REQUEST_IN(irq), .IRQ_ACCEPT_OUT(irq_acc));
  iex_mem_model iex_mem_model_inst (.clk_in(clk), .rst_in(rst), .slow_in(slow), .req_in(mreq), .we_in(mwe),
    .addr_in(maddr), .wdata_in(mwdata), .rdata_out(mrdata), .ack_out(mack));
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs
  function automatic logic [15:0] enc(input logic [10:0] op, input logic [3:0] r);
    return {op, 1'b0, r};
  endfunction : enc
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // One APB transfer: setup, access, hold until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk,
                     output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    want <= chk;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic er(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] rd;
    rd_q.push_back({err, d});
    apb(1'b0, a, 32'h00000000, 1'b1, rd);
  endtask : er
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    apb(1'b1, a, d, 1'b0, rd);
  endtask : wr
  task automatic ew(input logic [15:0] a, input logic [15:0] d);
    wr_q.push_back({a, d});
  endtask : ew
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Compare each completed result with the oldest expectation
  always @(posedge clk) begin
    if (!rst && psel && penable && pready && !pwrite && want) begin
      e_rd = rd_q.size() != 0 ? rd_q.pop_front() : 33'h1FFFFFFFF;
      check("apb read data", prdata, e_rd[31:0]);
      check("apb error flag", {31'h0, pslverr}, {31'h0, e_rd[32]});
    end
    if (mreq && mack && mwe) begin
      check("mem write", {maddr, mwdata}, wr_q.size() != 0 ? wr_q.pop_front() : 32'h0);
    end
    if (irq_acc) irq_total++;
    if (irq_acc && in_win) irq_win++;
    if (mreq && mack && mwe && maddr == 16'h031E) in_win <= 1'b1;
    else if (mreq && mack && !mwe) in_win <= 1'b0;
  end
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [15:0] ra, rb, v;
    logic [15:0] prog [0:21];
    int k;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    irq <= 1'b1;
    er(iex_pkg::REG_PC_OFS, 32'h00000000, 1'b0);
    er(iex_pkg::REG_WS_OFS, 32'h00000000, 1'b0);
    er(iex_pkg::REG_STW_OFS, 32'h00000000, 1'b0);
    er(8'h14, 32'h00000000, 1'b1);
    for (int run = 0; run < 2; run++) begin
      seed = xs(seed);
      ra = seed;
      seed = xs(seed);
      rb = seed;
      v = (16'h1333 & ra) | rb;
      prog = '{enc(iex_pkg::OPC_LMK, 4'h0), 16'h0005, enc(iex_pkg::OPC_LDI, 4'h6), 16'h7FFF,
        enc(iex_pkg::OPC_ADI, 4'h6), 16'h0001, enc(iex_pkg::OPC_LDI, 4'h2), 16'h1234, enc(iex_pkg::OPC_ADI, 4'h2),
        16'h00FF, enc(iex_pkg::OPC_ANDV, 4'h2), ra, enc(iex_pkg::OPC_ORV, 4'h2), rb, enc(iex_pkg::OPC_CPI, 4'h2),
        v, enc(iex_pkg::OPC_SWB, 4'h3), enc(iex_pkg::OPC_SSW, 4'h4), {iex_pkg::OPC_TRAP, 4'h3,
        iex_pkg::MODE_IND, 4'h5}, enc(iex_pkg::OPC_LWB, 4'h0), 16'h0180, 16'h0000};
      for (k = 0; k < 22; k++) iex_mem_model_inst.mem[15'h0100 + k] = prog[k];
      iex_mem_model_inst.mem[15'h0026] = 16'h0300;
      iex_mem_model_inst.mem[15'h0027] = 16'h0400;
      iex_mem_model_inst.mem[15'h0085] = 16'hFF00;
      iex_mem_model_inst.mem[15'h0200] = enc(iex_pkg::OPC_SSW, 4'h0);
      iex_mem_model_inst.mem[15'h0201] = enc(iex_pkg::OPC_RET, 4'h0);
      slow <= run[0];
      wr(iex_pkg::REG_WS_OFS, 32'h00000100);
      wr(iex_pkg::REG_PC_OFS, 32'h00000200);
      ew(16'h010C, 16'h7FFF);
      ew(16'h010C, 16'h8000);
      ew(16'h0104, 16'h1234);
      ew(16'h0104, 16'h1333);
      ew(16'h0104, 16'h1333 & ra);
      ew(16'h0104, v);
      ew(16'h0106, 16'h0100);
      ew(16'h0108, 16'h2005);
      ew(16'h0316, 16'hFF00);
      ew(16'h031A, 16'h0100);
      ew(16'h031C, 16'h0226);
      ew(16'h031E, 16'h2005);
      ew(16'h0300, 16'h2205);
      wr(iex_pkg::REG_CTRL_OFS, 32'h00000001);
      k = 0;
      rd = 32'h00000001;
      while (rd[0] !== 1'b0 && k < 500) begin
        apb(1'b0, iex_pkg::REG_STATE_OFS, 32'h00000000, 1'b0, rd);
        k++;
      end
      er(iex_pkg::REG_STATE_OFS, 32'h00000002, 1'b0);
      er(iex_pkg::REG_WS_OFS, 32'h00000180, 1'b0);
      er(iex_pkg::REG_STW_OFS, 32'h00002005, 1'b0);
      check("writes left", 32'(wr_q.size()), 32'h0);
      $display("test %0d done", run);
    end
    check("irq after trap", 32'(irq_win), 32'h0);
    check("irq accepted", {31'h0, irq_total != 0}, 32'h1);
    wrap_up();
  end
endmodule : tb
